// ==== core/dsp_decoder_consts.vh ====
/*
 * constants for the instruction decoder: opcode patterns, datapath
 * operation codes and field positions.
 * assumes it is included by bare name from design and test files.
 */
`ifndef DSP_DECODER_CONSTS_VH
`define DSP_DECODER_CONSTS_VH

// field positions inside the 16-bit word
`define F_TOP_HI      15
`define F_TOP_LO      12
`define F_SHIFT_HI    11
`define F_SHIFT_LO    8
`define F_STX_HI      10
`define F_STX_LO      8
`define F_IMODE       7
`define F_DMA_HI      6
`define F_INC         5
`define F_DEC         4
`define F_KEEPSEL     3
`define F_NEWSEL      0
`define F_AUXR        8

// whole-word encodings
`define W_MAGNITUDE   16'h7F88
`define W_CLEAR_ACC   16'h7F89

// top-nibble encodings
`define N_ADD_SHIFT   4'h0
`define N_SUB_SHIFT   4'h1
`define N_LOAD_SHIFT  4'h2
`define N_IO_GROUP    4'h4
`define N_BRANCH      4'hF
`define T_MULT_CONST  3'h4

// high-byte encodings
`define B_ADD_UPPER   8'h60
`define B_ADD_LOWER   8'h61
`define B_SUB_UPPER   8'h62
`define B_SUB_LOWER   8'h63
`define B_COND_STEP   8'h64
`define B_CLR_UPPER   8'h65
`define B_CLR_LOWER   8'h66
`define B_AUX_MODIFY  8'h68
`define B_PAGE_CONST  8'h6E
`define B_PAGE_MEM    8'h6F
`define B_XOR         8'h78
`define B_AND         8'h79
`define B_OR          8'h7A
`define B_ACC_CONST   8'h7E
`define B_MISC        8'h7F
`define B_STORE_LOW   8'h50
`define P_STORE_UP    5'h0B
`define P_AUX_CONST   7'h38
`define P_AUX_LOAD    7'h1C
`define P_AUX_STORE   7'h18

// datapath operation codes
`define OP_NONE       5'h00
`define OP_ADD_SHIFT  5'h01
`define OP_ADD_UPPER  5'h02
`define OP_ADD_LOWER  5'h03
`define OP_SUB_SHIFT  5'h04
`define OP_SUB_UPPER  5'h05
`define OP_SUB_LOWER  5'h06
`define OP_COND_STEP  5'h07
`define OP_AND        5'h08
`define OP_OR         5'h09
`define OP_XOR        5'h0A
`define OP_LOAD_SHIFT 5'h0B
`define OP_ACC_CONST  5'h0C
`define OP_MAGNITUDE  5'h0D
`define OP_CLEAR      5'h0E
`define OP_CLR_UPPER  5'h0F
`define OP_CLR_LOWER  5'h10
`define OP_MULT_CONST 5'h11
`define OP_STORE_UP   5'h12
`define OP_STORE_LOW  5'h13
`define OP_AUX_STORE  5'h14

// reset values
`define RST_PAGE      1'h0
`define RST_SEL       1'h0
`define RST_AUX       16'h0000

`endif

// ==== core/dsp_instruction_decoder.v ====
/*
 * single-cycle instruction decoder for the accumulator, memory-reference,
 * auxiliary-register and page-pointer groups. it also keeps the page
 * pointer, the auxiliary selector and both auxiliary registers, since
 * they form operand addresses.
 * assumes one fetched word per instrValid cycle, synchronous to sys_clk,
 * and that memData already holds the operand for loads from memory.
 */
`timescale 1ns/1ps
`include "dsp_decoder_consts.vh"

// Contract
// - top bits 100: 13-bit constant multiply
// - 7E: byte constant into cleared accumulator
// - 7F88 replaces accumulator by magnitude
// - nibble 0: add operand shifted by count
// - 60: add operand to upper half
// - 61: unsigned add to lower half
// - 79/7A/78: and, or, xor low
// - nibble 2: load accumulator shifted
// - 58-5F store upper shifted, 50 lower
// - nibble 1: subtract operand shifted
// - 62/63 subtract halves, 64 division step
// - 7F89 clears; 65 clears, loads upper
// - 66: clear, load lower unsigned
// - aux constant, load, store by R
// - 68 modifies aux; 688K loads selector
// - 6F page from memory; 6E0K immediate
// - shift fields: four bits, three bits
// - bit 7 mode, bits 6-0 address
// - every listed instruction: one word, cycle
// - direct: page bit joins 7-bit field
// - indirect: low byte of selected aux
module dsp_instruction_decoder (
    input  wire        sys_clk,          // processor clock
    input  wire        rst,              // async reset, active high
    input  wire        instrValid,       // fetched word present
    input  wire [15:0] instrWord,        // fetched instruction word
    input  wire [15:0] memData,          // operand read for this word
    output reg         opValid,          // one pulse per decoded word
    output reg  [4:0]  aluOp,            // accumulator datapath operation
    output reg  [3:0]  shiftCount,       // left shift for operand or store
    output reg  [12:0] immValue,         // immediate constant, zero-filled
    output reg  [7:0]  dataAddr,         // data memory address
    output reg         memRead,          // operand read from dataAddr
    output reg         memWrite,         // result written to dataAddr
    output reg  [15:0] auxValue,         // aux register value for stores
    output reg         auxSelectPointer, // current aux register selector
    output reg         pagePointer,      // data page pointer
    output reg         neighbourOp,      // word of another decoder group
    output reg         illegalOp         // unknown encoding seen
);

////////////////////////////////////////////////////////////////////////////////
// state and next values

reg  [15:0] auxReg0;             // auxiliary register 0
reg  [15:0] auxReg1;             // auxiliary register 1
reg  [4:0]  next_aluOp;          // decoded operation
reg  [3:0]  next_shiftCount;     // decoded shift
reg  [12:0] next_immValue;       // decoded constant
reg         next_memRead;        // decoded read
reg         next_memWrite;       // decoded write
reg  [15:0] next_auxValue;       // aux value to store
reg         next_neighbour;      // other group
reg         next_illegal;        // unknown word
reg         next_sel;            // selector after this word
reg         next_page;           // page after this word
reg  [15:0] next_aux0;           // aux 0 after this word
reg  [15:0] next_aux1;           // aux 1 after this word
reg         usesAddr;            // word carries I and D fields
reg         auxLoad;             // aux register load from memory
reg         auxConst;            // aux register load from constant
reg         auxTarget;           // register picked by R

wire [7:0]  highByte  = instrWord[15:8];
wire [3:0]  topNibble = instrWord[`F_TOP_HI:`F_TOP_LO];
wire        indirect  = instrWord[`F_IMODE];
wire [15:0] selAux    = auxSelectPointer ? auxReg1 : auxReg0;
// indirect takes the selected register, direct joins page and field
wire [7:0]  operandAddr = indirect ? selAux[7:0]
                        : {pagePointer, instrWord[`F_DMA_HI:0]};

////////////////////////////////////////////////////////////////////////////////
// decode: every listed word settles in this one cycle, no sequencing

always @*
begin
    next_aluOp      = `OP_NONE;
    next_shiftCount = 4'h0;
    next_immValue   = 13'h0000;
    next_memRead    = 1'b0;
    next_memWrite   = 1'b0;
    next_auxValue   = 16'h0000;
    next_neighbour  = 1'b0;
    next_illegal    = 1'b0;
    usesAddr        = 1'b0;
    auxLoad         = 1'b0;
    auxConst        = 1'b0;
    auxTarget       = instrWord[`F_AUXR];
    next_page       = pagePointer;
    if (instrWord[15:13] == `T_MULT_CONST)
    begin
        // constant times temporary register into product
        next_aluOp    = `OP_MULT_CONST;
        next_immValue = instrWord[12:0];
    end
    else if (instrWord == `W_MAGNITUDE)
        next_aluOp = `OP_MAGNITUDE;
    else if (instrWord == `W_CLEAR_ACC)
        next_aluOp = `OP_CLEAR;
    else if (topNibble == `N_ADD_SHIFT || topNibble == `N_SUB_SHIFT
             || topNibble == `N_LOAD_SHIFT)
    begin
        // four-bit shift field applies to the operand
        next_shiftCount = instrWord[`F_SHIFT_HI:`F_SHIFT_LO];
        next_memRead    = 1'b1;
        usesAddr        = 1'b1;
        if (topNibble == `N_ADD_SHIFT)
            next_aluOp = `OP_ADD_SHIFT;
        else if (topNibble == `N_SUB_SHIFT)
            next_aluOp = `OP_SUB_SHIFT;
        else
            next_aluOp = `OP_LOAD_SHIFT;
    end
    else if (highByte[7:3] == `P_STORE_UP)
    begin
        // three-bit shift applies to the accumulator before storing
        next_aluOp      = `OP_STORE_UP;
        next_shiftCount = {1'b0, instrWord[`F_STX_HI:`F_STX_LO]};
        next_memWrite   = 1'b1;
        usesAddr        = 1'b1;
    end
    else if (highByte == `B_STORE_LOW)
    begin
        next_aluOp    = `OP_STORE_LOW;
        next_memWrite = 1'b1;
        usesAddr      = 1'b1;
    end
    else if (highByte[7:1] == `P_AUX_CONST)
    begin
        auxConst      = 1'b1;
        next_immValue = {5'h00, instrWord[7:0]};
    end
    else if (highByte[7:1] == `P_AUX_LOAD)
    begin
        auxLoad      = 1'b1;
        next_memRead = 1'b1;
        usesAddr     = 1'b1;
    end
    else if (highByte[7:1] == `P_AUX_STORE)
    begin
        next_aluOp    = `OP_AUX_STORE;
        next_auxValue = instrWord[`F_AUXR] ? auxReg1 : auxReg0;
        next_memWrite = 1'b1;
        usesAddr      = 1'b1;
    end
    else if (highByte == `B_ACC_CONST)
    begin
        // constant lands right-justified, upper 24 bits cleared
        next_aluOp    = `OP_ACC_CONST;
        next_immValue = {5'h00, instrWord[7:0]};
    end
    else if (highByte == `B_AUX_MODIFY)
        usesAddr = 1'b1;                 // address side effects only
    else if (highByte == `B_PAGE_MEM)
    begin
        next_page    = memData[0];
        next_memRead = 1'b1;
        usesAddr     = 1'b1;
    end
    else if (highByte == `B_PAGE_CONST)
    begin
        // only the documented form loads; other low bits are unknown words
        if (instrWord[7:1] == 7'h00)
            next_page = instrWord[0];
        else
            next_illegal = 1'b1;
    end
    else if (highByte[7:4] == 4'h6 || highByte[7:3] == 5'h0F)
    begin
        next_memRead = 1'b1;
        usesAddr     = 1'b1;
        case (highByte)
            `B_ADD_UPPER: next_aluOp = `OP_ADD_UPPER;
            `B_ADD_LOWER: next_aluOp = `OP_ADD_LOWER;
            `B_SUB_UPPER: next_aluOp = `OP_SUB_UPPER;
            `B_SUB_LOWER: next_aluOp = `OP_SUB_LOWER;
            `B_COND_STEP: next_aluOp = `OP_COND_STEP;
            `B_CLR_UPPER: next_aluOp = `OP_CLR_UPPER;
            `B_CLR_LOWER: next_aluOp = `OP_CLR_LOWER;
            `B_AND:       next_aluOp = `OP_AND;
            `B_OR:        next_aluOp = `OP_OR;
            `B_XOR:       next_aluOp = `OP_XOR;
            8'h67, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D,
            8'h7B, 8'h7C, 8'h7D, `B_MISC:
            begin
                // multiply, table, status and misc words go elsewhere
                next_memRead   = 1'b0;
                usesAddr       = 1'b0;
                next_neighbour = 1'b1;
            end
            default:
            begin
                next_memRead = 1'b0;
                usesAddr     = 1'b0;
                next_illegal = 1'b1;
            end
        endcase
    end
    else if (topNibble == `N_IO_GROUP || topNibble == `N_BRANCH)
        next_neighbour = 1'b1;
    else
        next_illegal = 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// aux register and selector updates, including indirect side effects

always @*
begin
    next_aux0 = auxReg0;
    next_aux1 = auxReg1;
    next_sel  = auxSelectPointer;
    // post-modify of the selected register after an indirect access
    if (usesAddr && indirect)
    begin
        if (instrWord[`F_INC])
        begin
            if (auxSelectPointer)
                next_aux1 = auxReg1 + 16'h0001;
            else
                next_aux0 = auxReg0 + 16'h0001;
        end
        else if (instrWord[`F_DEC])
        begin
            if (auxSelectPointer)
                next_aux1 = auxReg1 - 16'h0001;
            else
                next_aux0 = auxReg0 - 16'h0001;
        end
        // bit 3 low loads the selector; 688K is this form of modify
        if (!instrWord[`F_KEEPSEL])
            next_sel = instrWord[`F_NEWSEL];
    end
    // an explicit load wins over the post-modify of the same register
    if (auxLoad || auxConst)
    begin
        if (auxTarget)
            next_aux1 = auxConst ? {8'h00, instrWord[7:0]} : memData;
        else
            next_aux0 = auxConst ? {8'h00, instrWord[7:0]} : memData;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs; one word in, one result out, no stall

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        opValid          <= 1'b0;
        aluOp            <= `OP_NONE;
        shiftCount       <= 4'h0;
        immValue         <= 13'h0000;
        dataAddr         <= 8'h00;
        memRead          <= 1'b0;
        memWrite         <= 1'b0;
        auxValue         <= 16'h0000;
        neighbourOp      <= 1'b0;
        illegalOp        <= 1'b0;
        auxSelectPointer <= `RST_SEL;
        pagePointer      <= `RST_PAGE;
        auxReg0          <= `RST_AUX;
        auxReg1          <= `RST_AUX;
    end
    else if (instrValid)
    begin
        opValid          <= 1'b1;
        aluOp            <= next_aluOp;
        shiftCount       <= next_shiftCount;
        immValue         <= next_immValue;
        dataAddr         <= usesAddr ? operandAddr : 8'h00;
        memRead          <= next_memRead;
        memWrite         <= next_memWrite;
        auxValue         <= next_auxValue;
        neighbourOp      <= next_neighbour;
        illegalOp        <= next_illegal;
        auxSelectPointer <= next_sel;
        pagePointer      <= next_page;
        auxReg0          <= next_aux0;
        auxReg1          <= next_aux1;
    end
    else
    begin
        // idle cycle: drop strobes so nothing repeats
        opValid     <= 1'b0;
        aluOp       <= `OP_NONE;
        memRead     <= 1'b0;
        memWrite    <= 1'b0;
        neighbourOp <= 1'b0;
        illegalOp   <= 1'b0;
    end
end

endmodule

// ==== test/dsp_decoder_props.sv ====
/*
 * checker for the instruction decoder, watching only its ports.
 * assumes one clock sys_clk and async active-high rst; bound below.
 */
`timescale 1ns/1ps
`include "dsp_decoder_consts.vh"
module dsp_decoder_props (
    input wire        sys_clk,          // clock
    input wire        rst,              // async reset
    input wire        instrValid,       // word present
    input wire [15:0] instrWord,        // fetched word
    input wire [15:0] memData,          // operand
    input wire        opValid,          // decode pulse
    input wire [4:0]  aluOp,            // datapath op
    input wire [3:0]  shiftCount,       // shift count
    input wire [12:0] immValue,         // immediate
    input wire [7:0]  dataAddr,         // operand address
    input wire        memRead,          // read pulse
    input wire        memWrite,         // write pulse
    input wire [15:0] auxValue,         // aux value
    input wire        auxSelectPointer, // aux selector
    input wire        pagePointer,      // page pointer
    input wire        neighbourOp,      // other group
    input wire        illegalOp         // unknown word
);
    reg [15:0] lastWord; // word taken at the previous edge
    ////////////////////////////////////////////////////////////////////////////////
    // a register instead of $past on a slice, which some tools refuse
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            lastWord <= 16'h0000;
        else
            lastWord <= instrWord;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_one_cycle; instrValid |=> opValid; endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("word not answered");
    property p_quiet; !instrValid [*2] |=> !opValid && !memRead && !memWrite; endproperty
    a_quiet: assert property (p_quiet) else $error("output without word");
    property p_mult; instrValid && instrWord[15:13] == 3'h4
        |=> aluOp == `OP_MULT_CONST && immValue == lastWord[12:0]; endproperty
    a_mult: assert property (p_mult) else $error("constant multiply wrong");
    property p_acc_const; instrValid && instrWord[15:8] == 8'h7E
        |=> aluOp == `OP_ACC_CONST && immValue == {5'h00, lastWord[7:0]}; endproperty
    a_acc_const: assert property (p_acc_const) else $error("byte load wrong");
    property p_magnitude; instrValid && instrWord == `W_MAGNITUDE |=> aluOp == `OP_MAGNITUDE;
    endproperty
    a_magnitude: assert property (p_magnitude) else $error("magnitude wrong");
    property p_add_shift; instrValid && instrWord[15:12] == 4'h0
        |=> aluOp == `OP_ADD_SHIFT && shiftCount == lastWord[11:8] && memRead; endproperty
    a_add_shift: assert property (p_add_shift) else $error("shifted add wrong");
    property p_store_up; instrValid && instrWord[15:11] == 5'h0B
        |=> aluOp == `OP_STORE_UP && shiftCount == {1'b0, lastWord[10:8]} && memWrite; endproperty
    a_store_up: assert property (p_store_up) else $error("upper store wrong");
    property p_direct; instrValid && instrWord[15:14] == 2'h0 && instrWord[13:12] != 2'h3
        && !instrWord[7] |=> dataAddr == {$past(pagePointer), lastWord[6:0]}; endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");
    property p_illegal; illegalOp |-> aluOp == `OP_NONE && !memRead && !memWrite
        && $stable(pagePointer) && $stable(auxSelectPointer); endproperty
    a_illegal: assert property (p_illegal) else $error("illegal word acted");
    property p_page_const; instrValid && instrWord[15:1] == 15'h3700
        |=> pagePointer == lastWord[0]; endproperty
    a_page_const: assert property (p_page_const) else $error("page load wrong");
    c_illegal: cover property (illegalOp);
    c_neighbour: cover property (neighbourOp);
    c_aux_store: cover property (memWrite && auxValue != 16'h0000);
endmodule
bind dsp_instruction_decoder dsp_decoder_props i_dsp_decoder_props (
    .sys_clk(sys_clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .memData(memData), .opValid(opValid), .aluOp(aluOp), .shiftCount(shiftCount),
    .immValue(immValue), .dataAddr(dataAddr), .memRead(memRead), .memWrite(memWrite),
    .auxValue(auxValue), .auxSelectPointer(auxSelectPointer), .pagePointer(pagePointer),
    .neighbourOp(neighbourOp), .illegalOp(illegalOp));

// ==== test/program_memory.sv ====
/*
 * program memory model: one-cycle fetch of a word and its operand.
 * assumes the bench fills codeMem and dataMem before a fetch.
 */
`timescale 1ns/1ps
module program_memory (
    input  wire        sys_clk,    // clock
    input  wire        fetchEn,    // fetch request
    input  wire [7:0]  fetchAddr,  // fetch slot
    output reg         instrValid, // word present
    output reg  [15:0] instrWord,  // fetched word
    output reg  [15:0] memData     // operand for that word
);
    reg [15:0] codeMem [0:255]; // instruction words
    reg [15:0] dataMem [0:255]; // operands
    initial
    begin
        instrValid = 1'b0;
        instrWord  = 16'h0000;
        memData    = 16'h0000;
    end
    // between fetches the buses toggle so stale words are never reused
    always @(posedge sys_clk)
    begin
        instrValid <= fetchEn;
        instrWord  <= fetchEn ? codeMem[fetchAddr] : ~instrWord;
        memData    <= fetchEn ? dataMem[fetchAddr] : ~memData;
    end
endmodule

// ==== test/testbench.sv ====
/*
 * self-checking bench for the instruction decoder.
 * assumes program_memory feeds words; expectations queued in issue order.
 */
`timescale 1ns/1ps
`include "dsp_decoder_consts.vh"
module testbench;
    reg         sys_clk;   // 200 MHz clock
    reg         rst;       // async reset
    reg         fetchEn;   // fetch request
    reg  [7:0]  fetchAddr; // fetch slot
    reg  [7:0]  ptr;       // next free slot
    wire        instrValid, opValid, memRead, memWrite;
    wire        auxSelectPointer, pagePointer, neighbourOp, illegalOp;
    wire [15:0] instrWord, memData, auxValue;
    wire [4:0]  aluOp;
    wire [3:0]  shiftCount;
    wire [12:0] immValue;
    wire [7:0]  dataAddr;
    integer     fails, comparisons, i;
    reg  [99:0] expQ [$];  // {mask, expected}
    reg  [99:0] note;      // oldest note
    reg  [31:0] r;         // random draw
    reg  [7:0]  hb;        // table high byte
    localparam [49:0] NOA = 50'h3FFFFF00FFFFF; // address unchecked
    localparam [95:0] HB = {8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65,
                            8'h66, 8'h78, 8'h79, 8'h7A, 8'h1F, 8'h20};
    localparam [59:0] OB = {`OP_ADD_UPPER, `OP_ADD_LOWER, `OP_SUB_UPPER, `OP_SUB_LOWER,
                            `OP_COND_STEP, `OP_CLR_UPPER, `OP_CLR_LOWER, `OP_XOR,
                            `OP_AND, `OP_OR, `OP_SUB_SHIFT, `OP_LOAD_SHIFT};
    dsp_instruction_decoder i_dsp_instruction_decoder (.sys_clk(sys_clk), .rst(rst),
        .instrValid(instrValid), .instrWord(instrWord), .memData(memData),
        .opValid(opValid), .aluOp(aluOp), .shiftCount(shiftCount), .immValue(immValue),
        .dataAddr(dataAddr), .memRead(memRead), .memWrite(memWrite), .auxValue(auxValue),
        .auxSelectPointer(auxSelectPointer), .pagePointer(pagePointer),
        .neighbourOp(neighbourOp), .illegalOp(illegalOp));
    program_memory i_program_memory (.sys_clk(sys_clk), .fetchEn(fetchEn),
        .fetchAddr(fetchAddr), .instrValid(instrValid), .instrWord(instrWord),
        .memData(memData));
    ////////////////////////////////////////////////////////////////////////////////
    function [49:0] ex(input [4:0] op, input [3:0] sh, input [12:0] imm, input [7:0] ad,
                       input [1:0] rw, input [1:0] ni, input [15:0] av);
        ex = {op, sh, imm, ad, rw, ni, av};
    endfunction
    task check(input [49:0] got, input [49:0] want);
    begin
        comparisons = comparisons + 1;
        if (got !== want)
        begin
            fails = fails + 1;
            $display("[ERR] %0t seen %h expected %h", $time, got, want);
        end
    end
    endtask
    // word goes to the memory and its expectation to the queue together
    task issue(input [15:0] w, input [15:0] d, input [49:0] e, input [49:0] m);
    begin
        @(posedge sys_clk);
        fetchEn   <= 1'b1;
        fetchAddr <= ptr;
        i_program_memory.codeMem[ptr] = w;
        i_program_memory.dataMem[ptr] = d;
        expQ.push_back({m, e & m});
        ptr = ptr + 8'h01;
    end
    endtask
    task idle(input integer n);
    begin
        @(posedge sys_clk);
        fetchEn <= 1'b0;
        repeat (n) @(posedge sys_clk);
    end
    endtask
    task close_out;
    begin
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // watchdog: the whole sequence needs about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        fails = fails + 1;
        close_out;
    end
    // each decode pulse consumes the oldest note
    always @(posedge sys_clk)
    begin
        if (!rst && opValid === 1'b1)
        begin
            note = expQ.pop_front();
            check({aluOp, shiftCount, immValue, dataAddr, memRead, memWrite, neighbourOp,
                   illegalOp, auxValue} & note[99:50], note[49:0]);
        end
    end
    initial
    begin
        rst = 1'b1; fetchEn = 1'b0; fetchAddr = 8'h00; ptr = 8'h00;
        fails = 0; comparisons = 0;
        r = $urandom(85); // seed once, first draw discarded
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        issue(16'h6E01, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 0, 0), NOA);
        issue(16'h0509, 16'h0000, ex(`OP_ADD_SHIFT, 4'h5, 0, 8'h89, 2, 0, 0), ~50'h0);
        issue(16'h7012, 16'h0000, ex(`OP_NONE, 0, 13'h0012, 0, 0, 0, 0), NOA);
        issue(16'h08A8, 16'h0000, ex(`OP_ADD_SHIFT, 4'h8, 0, 8'h12, 2, 0, 0), ~50'h0);
        issue(16'h3088, 16'h0000, ex(`OP_AUX_STORE, 0, 0, 8'h13, 1, 0, 16'h0013),
              ~50'h0);
        issue(16'h3988, 16'h00AB, ex(`OP_NONE, 0, 0, 8'h13, 2, 0, 0), ~50'h0);
        issue(16'h6881, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 0, 0), NOA);
        issue(16'h3188, 16'h0000, ex(`OP_AUX_STORE, 0, 0, 8'hAB, 1, 0, 16'h00AB),
              ~50'h0);
        // post-decrement of the selected register shows in the next store
        issue(16'h0898, 16'h0000, ex(`OP_ADD_SHIFT, 4'h8, 0, 8'hAB, 2, 0, 0), ~50'h0);
        issue(16'h3188, 16'h0000, ex(`OP_AUX_STORE, 0, 0, 8'hAA, 1, 0, 16'h00AA),
              ~50'h0);
        issue(16'h6F05, 16'hFFFE, ex(`OP_NONE, 0, 0, 8'h85, 2, 0, 0), ~50'h0);
        issue(16'h5B0A, 16'h0000, ex(`OP_STORE_UP, 4'h3, 0, 8'h0A, 1, 0, 0), ~50'h0);
        issue(16'h5003, 16'h0000, ex(`OP_STORE_LOW, 0, 0, 8'h03, 1, 0, 0), ~50'h0);
        for (i = 0; i < 12; i = i + 1)
        begin
            hb = HB[8*(11-i) +: 8];
            issue({hb, 1'b0, 7'h7F - i[6:0]}, 16'h0000, ex(OB[5*(11-i) +: 5],
                  (hb[7:5] == 3'h0) ? hb[3:0] : 4'h0, 0, {1'b0, 7'h7F - i[6:0]}, 2, 0, 0),
                  ~50'h0);
        end
        issue(16'h7EDD, 16'h0000, ex(`OP_ACC_CONST, 0, 13'h00DD, 0, 0, 0, 0), NOA);
        issue(16'h7F88, 16'h0000, ex(`OP_MAGNITUDE, 0, 0, 0, 0, 0, 0), NOA);
        issue(16'h7F89, 16'h0000, ex(`OP_CLEAR, 0, 0, 0, 0, 0, 0), NOA);
        issue(16'h9ADD, 16'h0000, ex(`OP_MULT_CONST, 0, 13'h1ADD, 0, 0, 0, 0), NOA);
        issue(16'h7F80, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 2, 0), NOA);
        issue(16'hF900, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 2, 0), NOA);
        issue(16'hA000, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 1, 0), NOA);
        issue(16'h7200, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 1, 0), NOA);
        issue(16'h6E03, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 1, 0), NOA);
        issue(16'h5400, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 1, 0), NOA);
        issue(16'h4800, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 2, 0), NOA);
        idle(4);
        check(opValid, 1'b0);
        check(pagePointer, 1'b0);
        check(auxSelectPointer, 1'b1);
        for (i = 0; i < 20; i = i + 1)
        begin
            r = $urandom;
            issue({4'h0, r[11:8], 1'b0, r[6:0]}, r[31:16],
                  ex(`OP_ADD_SHIFT, r[11:8], 0, {1'b0, r[6:0]}, 2, 0, 0), ~50'h0);
            issue({3'h4, r[28:16]}, 16'h0000, ex(`OP_MULT_CONST, 0, r[28:16], 0, 0, 0, 0),
                  NOA);
        end
        issue(16'h6E01, 16'h0000, ex(`OP_NONE, 0, 0, 0, 0, 0, 0), NOA);
        issue(16'h2A7F, 16'h0000, ex(`OP_LOAD_SHIFT, 4'hA, 0, 8'hFF, 2, 0, 0), ~50'h0);
        idle(6);
        check(pagePointer, 1'b1);
        check(expQ.size(), 0);
        close_out;
    end
endmodule
